// ### bcss_blit_cmd.sv
// Blit command decode, raster combine, source address split and read FIFO flow control.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - In a read transfer the engine pauses when the FIFO is full.
// - A paused read transfer resumes only when fewer than 14 entries are used.
// - Command bits 19-16 hold the 4-bit raster operation code.
// - Result bit equals code bit indexed by source and destination bits.
// - Pattern fill uses the same codes with pattern in place of source.
// - Color expansion start bit is code bits 2-0; bit 3 ignored.
// - Operations 0-3: write, read, move positive, move negative, with raster code.
// - Operation 4 is transparent write, 5 transparent positive move.
// - Operation 6 is pattern fill with raster code, 7 with transparency.
// - Operations 8-11 are color expansion variants, plain or transparent, with move.
// - Operation 12 is solid fill; 13 to 15 are reserved.
// - Source start address register holds a 21-bit byte address.
// - For host-sourced data only source address bit 0 is used.
// - Pattern source address is base plus line offset plus pixel offset.
// - Pattern split: 8 bpp 20:6/5:3/2:0, 16 bpp 20:7/6:4/3:0.
// - Format bit zero selects 8 bpp, one selects 16 bpp.
// - Writing one to the write-only enable bit starts the operation.
// - Busy reads one during an operation and zero once complete.
module bcss_blit_cmd (
   // System.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Datapath handshake.
   input wire logic dp_done,
   input wire logic [4:0] fifo_used,
   input wire logic src_bit,
   input wire logic dst_bit,
   // Decoded command.
   output logic busy,
   output logic xfer_run,
   output logic [3:0] op_code,
   output logic rop_result,
   output logic [2:0] cexp_start,
   output logic transparent,
   output logic host_src,
   output logic [14:0] pat_base,
   output logic [2:0] pat_line,
   output logic [3:0] pat_pixel,
   output logic irq
);
   import bcss_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [31:0] cmd_q;
   logic [20:0] src_q;
   logic fmt_q;
   logic [1:0] ist_q;
   logic [1:0] imask_q;
   bcss_state_e st_q;
   logic req;
   logic wr;
   logic start;
   logic rsvd;
   logic is_read;
   logic done_ev;
   logic [31:0] rd_d;
   logic [31:0] wmask;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   // A start is only taken while idle, so a stray enable write cannot restart a transfer.
   assign start = wr && wb_adr_i == BCSS_OFF_CTRL && wb_sel_i[0] && wb_dat_i[BCSS_CTRL_EN_BIT]
      && st_q == BCSS_S_IDLE;
   assign rsvd = cmd_q[3:0] > BCSS_OP_SOLID;
   assign is_read = cmd_q[3:0] == BCSS_OP_READ;
   assign done_ev = st_q == BCSS_S_DONE;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_q <= BCSS_CMD_RST;
         src_q <= BCSS_SRC_RST[20:0];
         fmt_q <= 1'b0;
         imask_q <= 2'b00;
      end else if (wr) begin
         if (wb_adr_i == BCSS_OFF_CMD) begin
            cmd_q <= (cmd_q & ~wmask) | (wb_dat_i & wmask & 32'h000f_000f);
         end
         if (wb_adr_i == BCSS_OFF_SRC) begin
            src_q <= ((src_q & ~wmask[20:0]) | (wb_dat_i[20:0] & wmask[20:0]));
         end
         if (wb_adr_i == BCSS_OFF_CTRL && wb_sel_i[2]) begin
            fmt_q <= wb_dat_i[BCSS_CTRL_FMT_BIT];
         end
         if (wb_adr_i == BCSS_OFF_IRQ_MASK && wb_sel_i[0]) begin
            imask_q <= wb_dat_i[1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= BCSS_S_IDLE;
      end else begin
         case (st_q)
            BCSS_S_IDLE: begin
               if (start) begin
                  st_q <= rsvd ? BCSS_S_DONE : BCSS_S_RUN;
               end
            end
            BCSS_S_RUN: begin
               if (dp_done) begin
                  st_q <= BCSS_S_DONE;
               end else if (is_read && fifo_used >= BCSS_FIFO_DEPTH) begin
                  st_q <= BCSS_S_PAUSE;
               end
            end
            BCSS_S_PAUSE: begin
               if (fifo_used < BCSS_FIFO_RESUME) begin
                  st_q <= BCSS_S_RUN;
               end
            end
            BCSS_S_DONE: st_q <= BCSS_S_IDLE;
            default: st_q <= BCSS_S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interrupts: bit 0 done, bit 1 read paused on full FIFO
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ist_q <= 2'b00;
      end else begin
         // Set wins over a clear in the same cycle.
         ist_q <= (ist_q & ~((wr && wb_adr_i == BCSS_OFF_IRQ_STAT && wb_sel_i[0]) ?
            wb_dat_i[1:0] : 2'b00)) | {st_q == BCSS_S_RUN && is_read && !dp_done
            && fifo_used >= BCSS_FIFO_DEPTH, done_ev};
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ist_q & imask_q);
      end
   end

   // ---------------------------------------------------------------
   // Bus read and acknowledge
   // ---------------------------------------------------------------
   always_comb begin
      rd_d = 32'h0000_0000;
      case (wb_adr_i)
         BCSS_OFF_CTRL: rd_d = {13'h0000, fmt_q, 18'h00000};
         BCSS_OFF_STATUS: rd_d = {3'h0, fifo_used, 3'h0, BCSS_FIFO_DEPTH - fifo_used, 9'h000,
            fifo_used != 5'h00, fifo_used >= 5'h07, fifo_used >= 5'h0f, 3'h0,
            st_q != BCSS_S_IDLE};
         BCSS_OFF_CMD: rd_d = cmd_q;
         BCSS_OFF_SRC: rd_d = {11'h000, src_q};
         BCSS_OFF_IRQ_STAT: rd_d = {30'h0000_0000, ist_q};
         BCSS_OFF_IRQ_MASK: rd_d = {30'h0000_0000, imask_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Unmapped addresses are acknowledged and read as zero.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_d : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Decoded outputs
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         xfer_run <= 1'b0;
         op_code <= 4'h0;
         transparent <= 1'b0;
         host_src <= 1'b0;
         cexp_start <= 3'h0;
      end else begin
         busy <= (st_q == BCSS_S_IDLE) ? start : !done_ev;
         xfer_run <= (st_q == BCSS_S_IDLE && start && !rsvd)
            || (st_q == BCSS_S_RUN && !dp_done && !(is_read && fifo_used >= BCSS_FIFO_DEPTH))
            || (st_q == BCSS_S_PAUSE && fifo_used < BCSS_FIFO_RESUME);
         op_code <= cmd_q[3:0];
         transparent <= cmd_q[3:0] == BCSS_OP_TWRITE || cmd_q[3:0] == BCSS_OP_TMOVE
            || cmd_q[3:0] == BCSS_OP_TPAT || cmd_q[3:0] == BCSS_OP_TCEXP
            || cmd_q[3:0] == BCSS_OP_TMCEXP;
         host_src <= cmd_q[3:0] == BCSS_OP_WRITE || cmd_q[3:0] == BCSS_OP_TWRITE
            || cmd_q[3:0] == BCSS_OP_CEXP || cmd_q[3:0] == BCSS_OP_TCEXP;
         cexp_start <= cmd_q[BCSS_CMD_ROP_LSB +: 3];
      end
   end

   // The operand bit is source or pattern alike; the caller feeds the pattern in fill modes.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rop_result <= 1'b0;
      end else begin
         rop_result <= cmd_q[BCSS_CMD_ROP_LSB + {30'h0, src_bit, dst_bit}];
      end
   end

   // Host-sourced data keeps only the byte lane bit of the address.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pat_base <= 15'h0000;
         pat_line <= 3'h0;
         pat_pixel <= 4'h0;
      end else if (host_src) begin
         pat_base <= 15'h0000;
         pat_line <= 3'h0;
         pat_pixel <= {3'h0, src_q[0]};
      end else if (fmt_q) begin
         pat_base <= {1'b0, src_q[20:7]};
         pat_line <= src_q[6:4];
         pat_pixel <= src_q[3:0];
      end else begin
         pat_base <= src_q[20:6];
         pat_line <= src_q[5:3];
         pat_pixel <= {1'b0, src_q[2:0]};
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   read_pause_a: assert property ((st_q == BCSS_S_PAUSE) |-> !xfer_run)
      else $error("transfer runs while paused");
   resume_gate_a: assert property ((st_q == BCSS_S_PAUSE && fifo_used >= BCSS_FIFO_RESUME)
      |=> st_q == BCSS_S_PAUSE)
      else $error("resumed with 14 or more entries");
   rop_lookup_a: assert property (1 |=> rop_result ==
      $past(cmd_q[BCSS_CMD_ROP_LSB + {30'h0, src_bit, dst_bit}]))
      else $error("raster result wrong");
   cexp_pos_a: assert property (1 |=> cexp_start == $past(cmd_q[18:16]))
      else $error("expansion start wrong");
   op_field_a: assert property (1 |=> op_code == $past(cmd_q[3:0]))
      else $error("operation code wrong");
   rsvd_done_a: assert property ((start && rsvd) |=> st_q == BCSS_S_DONE ##1 !busy)
      else $error("reserved start not completed");
   start_busy_a: assert property (start |=> busy)
      else $error("start did not raise busy");
   busy_clear_a: assert property ((st_q == BCSS_S_DONE) |=> !busy)
      else $error("busy not cleared");
   split_8bpp_a: assert property ((!fmt_q && !host_src && $stable(src_q) && $stable(fmt_q))
      |=> pat_line == $past(src_q[5:3]))
      else $error("8 bpp line split wrong");

   // ---------------------------------------------------------------
   // Checks on flow control, busy, decode, combine, address split and register access
   // ---------------------------------------------------------------
   // Fixed truth-table points keep these checks independent of the lookup index.
   fill_stop_a: assert property (
      (st_q == BCSS_S_RUN && is_read && !dp_done && fifo_used >= BCSS_FIFO_DEPTH)
      |=> (st_q == BCSS_S_PAUSE && !xfer_run))
      else $error("read transfer kept filling a full FIFO");
   resume_run_a: assert property (
      (st_q == BCSS_S_PAUSE && fifo_used < BCSS_FIFO_RESUME) |=> (st_q == BCSS_S_RUN && xfer_run))
      else $error("paused transfer did not resume");
   active_busy_a: assert property (
      (st_q == BCSS_S_RUN || st_q == BCSS_S_PAUSE) |-> busy)
      else $error("busy low during a transfer");
   idle_busy_a: assert property (
      (st_q == BCSS_S_IDLE) |-> !busy)
      else $error("busy high while idle");
   cmd_field_a: assert property (
      cmd_q[31:20] == 12'h000 && cmd_q[15:4] == 12'h000)
      else $error("command register holds unused bits");
   rop_zero_a: assert property (
      (cmd_q[19:16] == 4'h0) |=> !rop_result)
      else $error("code 0 combine not zero");
   rop_one_a: assert property (
      (cmd_q[19:16] == 4'hf) |=> rop_result)
      else $error("code 15 combine not one");
   rop_xor_a: assert property (
      (cmd_q[19:16] == 4'h6) |=> rop_result == ($past(src_bit) ^ $past(dst_bit)))
      else $error("code 6 combine not exclusive or");
   rop_dst_a: assert property (
      (cmd_q[19:16] == 4'ha) |=> rop_result == $past(dst_bit))
      else $error("code 10 combine not destination");
   rop_pat_a: assert property (
      (cmd_q[19:16] == 4'hc) |=> rop_result == $past(src_bit))
      else $error("code 12 combine not source or pattern");
   transp_dec_a: assert property (
      (cmd_q[3:0] == BCSS_OP_TWRITE) |=> (transparent && host_src))
      else $error("transparent write decoded wrong");
   pat_dec_a: assert property (
      (cmd_q[3:0] == BCSS_OP_PAT) |=> (!transparent && !host_src))
      else $error("pattern fill decoded wrong");
   cexp_dec_a: assert property (
      (cmd_q[3:0] == BCSS_OP_TCEXP) |=> (transparent && host_src))
      else $error("transparent expansion decoded wrong");
   host_pix_a: assert property (
      host_src |=> (pat_pixel == {3'h0, $past(src_q[0])} && pat_line == 3'h0))
      else $error("host source address not reduced to bit 0");
   split_16bpp_a: assert property (
      (fmt_q && !host_src) |=> (pat_line == $past(src_q[6:4])
      && pat_pixel == $past(src_q[3:0])))
      else $error("16 bpp split wrong");
   base_8bpp_a: assert property (
      (!fmt_q && !host_src) |=> pat_base == $past(src_q[20:6]))
      else $error("8 bpp pattern base wrong");
   fmt_write_a: assert property (
      (wr && wb_adr_i == BCSS_OFF_CTRL && wb_sel_i[2])
      |=> fmt_q == $past(wb_dat_i[BCSS_CTRL_FMT_BIT]))
      else $error("format bit not stored");
   run_hold_a: assert property (
      (st_q == BCSS_S_RUN && !dp_done && !is_read) |=> st_q == BCSS_S_RUN)
      else $error("transfer left run without completion");
   rsvd_norun_a: assert property (
      (start && rsvd) |=> !xfer_run)
      else $error("reserved operation advanced the datapath");
   src_read_a: assert property (
      (req && !wb_we_i && wb_adr_i == BCSS_OFF_SRC) |=> wb_dat_o[31:21] == 11'h000)
      else $error("source address read wider than 21 bits");

   read_pause_c: cover property (st_q == BCSS_S_RUN ##1 st_q == BCSS_S_PAUSE);
   read_resume_c: cover property (st_q == BCSS_S_PAUSE ##1 st_q == BCSS_S_RUN);
   pat_16bpp_c: cover property (fmt_q && !host_src && st_q == BCSS_S_IDLE);
   rsvd_start_c: cover property (start && rsvd);
   done_irq_c: cover property (done_ev ##2 irq);
endmodule
`default_nettype wire

// ### bcss_blit_cmd_tb.sv
// Self-checking bench for the blit command block.
`timescale 1ns/100ps
`default_nettype none
module bcss_blit_cmd_tb;
   import bcss_pkg::*;
   localparam logic [31:0] PAT_ADR = 32'h0015_a5ed;
   logic sys_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dp_done, src_bit, dst_bit;
   logic busy, xfer_run, rop_result, transparent, host_src, irq, drain, finish;
   logic [15:0] wb_adr_i;
   logic [3:0] wb_sel_i, op_code, pat_pixel;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [4:0] fifo_used;
   logic [2:0] cexp_start, pat_line;
   logic [14:0] pat_base;
   int n_errors = 0;
   int comparisons = 0;
   bcss_blit_cmd i_bcss_blit_cmd (.sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dp_done, .fifo_used,
      .src_bit, .dst_bit, .busy, .xfer_run, .op_code, .rop_result, .cexp_start,
      .transparent, .host_src, .pat_base, .pat_line, .pat_pixel, .irq);
   bcss_dp_model i_bcss_dp_model (.sys_clk, .arst_n, .drain, .finish, .xfer_run,
      .fifo_used, .dp_done);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish;
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A missing ack is cut off after sixteen cycles rather than hanging.
   task automatic wb(input logic [15:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      q = wb_dat_o;
      chk(n < 16, 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic cmd(input logic [3:0] op, input logic [3:0] rop);
      wb(BCSS_OFF_CMD, 1'b1, {12'h000, rop, 12'h000, op});
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic await(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 64) begin
         n++;
         @(negedge sys_clk);
      end
      chk(s, v);
   endtask
   task automatic pulse(input logic fin);
      @(posedge sys_clk);
      if (fin) begin
         finish <= 1'b1;
      end else begin
         drain <= 1'b1;
      end
      @(posedge sys_clk);
      finish <= 1'b0;
      drain <= 1'b0;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      tally_and_finish;
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, src_bit, dst_bit, drain, finish} = '0;
      wb_adr_i = 16'h0000;
      wb_dat_i = 32'h0000_0000;
      wb_sel_i = 4'hf;
      arst_n = 1'b0;
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(BCSS_OFF_CMD, BCSS_CMD_RST);
      rd(BCSS_OFF_SRC, BCSS_SRC_RST);
      wb(16'h8100, 1'b1, 32'hffff_ffff);
      rd(16'h8100, 32'h0000_0000);
      wb(BCSS_OFF_CMD, 1'b1, 32'hffff_ffff);
      rd(BCSS_OFF_CMD, 32'h000f_000f);
      // Pattern address is base plus line offset plus pixel offset.
      wb(BCSS_OFF_SRC, 1'b1, PAT_ADR);
      rd(BCSS_OFF_SRC, PAT_ADR);
      for (int c = 0; c < 16; c++) begin
         cmd(c[0] ? BCSS_OP_PAT : BCSS_OP_WRITE, c[3:0]);
         for (int sd = 0; sd < 4; sd++) begin
            @(posedge sys_clk);
            src_bit <= sd[1];
            dst_bit <= sd[0];
            @(posedge sys_clk);
            @(negedge sys_clk);
            chk(rop_result, c[sd]);
         end
         chk(cexp_start, c[2:0]);
      end
      for (int o = 0; o < 13; o++) begin
         cmd(o[3:0], 4'h0);
         chk(op_code, o[3:0]);
         chk(transparent, 16'h0ab0 >> o & 16'h0001);
         chk(host_src, 16'h0311 >> o & 16'h0001);
      end
      cmd(BCSS_OP_PAT, 4'h0);
      for (int f = 0; f < 2; f++) begin
         wb(BCSS_OFF_CTRL, 1'b1, 32'(f) << BCSS_CTRL_FMT_BIT);
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk(pat_base, f ? {1'b0, PAT_ADR[20:7]} : PAT_ADR[20:6]);
         chk(pat_line, f ? PAT_ADR[6:4] : PAT_ADR[5:3]);
         chk(pat_pixel, f ? PAT_ADR[3:0] : {1'b0, PAT_ADR[2:0]});
      end
      cmd(BCSS_OP_WRITE, 4'h0);
      chk({pat_base, pat_line, pat_pixel}, {18'h00000, 3'h0, PAT_ADR[0]});
      wb(BCSS_OFF_IRQ_MASK, 1'b1, 32'h0000_0001);
      wb(BCSS_OFF_CTRL, 1'b1, 32'h0000_0001);
      await(busy, 1'b1);
      pulse(1'b1);
      await(busy, 1'b0);
      await(irq, 1'b1);
      rd(BCSS_OFF_IRQ_STAT, 32'h0000_0001);
      wb(BCSS_OFF_IRQ_STAT, 1'b1, 32'h0000_0001);
      await(irq, 1'b0);
      // The write run left a few entries in the FIFO; empty it before the read run.
      repeat (16) pulse(1'b0);
      cmd(BCSS_OP_READ, 4'h0);
      wb(BCSS_OFF_CTRL, 1'b1, 32'h0000_0001);
      await(xfer_run, 1'b1);
      await(xfer_run, 1'b0);
      chk(fifo_used, 5'h10);
      for (int k = 0; k < 3; k++) begin
         pulse(1'b0);
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         chk(xfer_run, k == 2);
      end
      rd(BCSS_OFF_IRQ_STAT, 32'h0000_0002);
      wb(BCSS_OFF_IRQ_STAT, 1'b1, 32'h0000_0003);
      pulse(1'b1);
      repeat (3) pulse(1'b0);
      await(busy, 1'b0);
      cmd(4'hd, 4'h0);
      wb(BCSS_OFF_CTRL, 1'b1, 32'h0000_0001);
      repeat (4) begin
         @(negedge sys_clk);
         chk(xfer_run, 1'b0);
      end
      chk(busy, 1'b0);
      tally_and_finish;
   end
endmodule
`default_nettype wire

// ### bcss_dp_model.sv
// Datapath and read FIFO model that faces the blit command block.
`timescale 1ns/100ps
`default_nettype none
module bcss_dp_model (
   // System.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Bench controls.
   input wire logic drain,
   input wire logic finish,
   // Block side.
   input wire logic xfer_run,
   output logic [4:0] fifo_used,
   output logic dp_done
);
   // The fill stops at sixteen, so a late pause shows as a stuck count.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fifo_used <= 5'h00;
      end else if (drain && fifo_used != 5'h00) begin
         fifo_used <= fifo_used - 5'h01;
      end else if (xfer_run && fifo_used < 5'h10) begin
         fifo_used <= fifo_used + 5'h01;
      end
   end
   logic pending_q;
   // A finish waits for a running cycle, since a paused datapath cannot complete.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pending_q <= 1'b0;
         dp_done <= 1'b0;
      end else begin
         pending_q <= finish || (pending_q && !xfer_run);
         dp_done <= pending_q && xfer_run;
      end
   end
endmodule
`default_nettype wire

// ### bcss_pkg.sv
// Package of register offsets, field positions, codes and widths for the blit command block.
package bcss_pkg;
   localparam logic [15:0] BCSS_OFF_CTRL = 16'h8000;
   localparam logic [15:0] BCSS_OFF_STATUS = 16'h8004;
   localparam logic [15:0] BCSS_OFF_CMD = 16'h8008;
   localparam logic [15:0] BCSS_OFF_SRC = 16'h800c;
   localparam logic [15:0] BCSS_OFF_IRQ_STAT = 16'h8040;
   localparam logic [15:0] BCSS_OFF_IRQ_MASK = 16'h8044;
   localparam int BCSS_CMD_ROP_LSB = 16;
   localparam int BCSS_CTRL_FMT_BIT = 18;
   localparam int BCSS_CTRL_EN_BIT = 0;
   localparam logic [31:0] BCSS_CMD_RST = 32'h0000_0000;
   localparam logic [31:0] BCSS_SRC_RST = 32'h0000_0000;
   localparam logic [4:0] BCSS_FIFO_DEPTH = 5'h10;
   localparam logic [4:0] BCSS_FIFO_RESUME = 5'h0e;
   localparam logic [3:0] BCSS_OP_WRITE = 4'h0;
   localparam logic [3:0] BCSS_OP_READ = 4'h1;
   localparam logic [3:0] BCSS_OP_MOVE_POS = 4'h2;
   localparam logic [3:0] BCSS_OP_MOVE_NEG = 4'h3;
   localparam logic [3:0] BCSS_OP_TWRITE = 4'h4;
   localparam logic [3:0] BCSS_OP_TMOVE = 4'h5;
   localparam logic [3:0] BCSS_OP_PAT = 4'h6;
   localparam logic [3:0] BCSS_OP_TPAT = 4'h7;
   localparam logic [3:0] BCSS_OP_CEXP = 4'h8;
   localparam logic [3:0] BCSS_OP_TCEXP = 4'h9;
   localparam logic [3:0] BCSS_OP_MCEXP = 4'ha;
   localparam logic [3:0] BCSS_OP_TMCEXP = 4'hb;
   localparam logic [3:0] BCSS_OP_SOLID = 4'hc;
   typedef enum logic [3:0] {
      BCSS_S_IDLE = 4'b0001,
      BCSS_S_RUN = 4'b0010,
      BCSS_S_PAUSE = 4'b0100,
      BCSS_S_DONE = 4'b1000
   } bcss_state_e;
endpackage
